// ===== bench/tb_usb_serial_passthrough_uart.sv
// Bench joining the device and external UART ends over one link
`timescale 1ns/100ps
module tb_usb_serial_passthrough_uart;
	localparam int          DIV = int'(uart_pass_pkg::DIV_115200);
	// Each entry: RTS pin selected, enabled, unsupported, control word
	localparam logic [34:0] CFG [7] = '{35'h3_0000_0033, 35'h2_0000_0433, 35'h3_0000_0223,
		35'h2_0000_0323, 35'h0_0000_0421, 35'h3_0000_0007, 35'h6_0000_002f};
	logic        core_clk = 1'b0;
	logic        rst_n    = 1'b0;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [11:0] paddr    = '0;
	logic [31:0] pwdata   = '0;
	logic        rd_chk   = 1'b0;
	logic        tx_valid = 1'b0;
	logic [7:0]  tx_data  = '0;
	logic        rx_hold  = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, gpio_tx_sel, gpio_rts_sel, tx_ready, rx_valid;
	logic [7:0]  rx_data;
	logic [31:0] lfsr = 32'hea48_36eb;
	logic [32:0] exp_rd[$];
	logic [7:0]  exp_ext[$];
	logic [7:0]  exp_dev[$];
	int          miscompares  = 0;
	int          total_checks = 0;
	uart_link_if link();

	always #2.5 core_clk = ~core_clk;

	uart_pass_dev #(.DEPTH(4), .NEAR_FULL(2)) uart_pass_dev_i (.CORE_CLK(core_clk), .RST_N(rst_n),
		.CLK_EN(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .GPIO_TX_SEL(gpio_tx_sel),
		.GPIO_RTS_SEL(gpio_rts_sel), .LINK(link));
	uart_pass_ext #(.DIV(uart_pass_pkg::DIV_115200)) uart_pass_ext_i (.CORE_CLK(core_clk), .RST_N(rst_n),
		.CLK_EN(1'b1), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .RX_VALID(rx_valid),
		.RX_DATA(rx_data), .RX_HOLD(rx_hold), .LINK(link));
	uart_link_sva #(.DIV(DIV)) uart_link_sva_i (.CORE_CLK(core_clk), .RST_N(rst_n), .dev_tx(link.dev_tx),
		.dev_rts_n(link.dev_rts_n), .ext_tx(link.ext_tx), .ext_cts_n(link.ext_cts_n));

	function automatic logic [31:0] next_lfsr(input logic [31:0] s);
		next_lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic chk,
		input logic [32:0] e, output logic [31:0] q);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		rd_chk <= chk;
		if (chk)
			exp_rd.push_back(e);
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_st(input int b, input logic v);
		logic [31:0] q;
		do
			apb(1'b0, uart_pass_pkg::OFS_STATUS, '0, 1'b0, '0, q);
		while (q[b] !== v);
	endtask

	task automatic ext_send(input logic [7:0] b);
		@(posedge core_clk);
		tx_valid <= 1'b1;
		tx_data <= b;
		do
			@(posedge core_clk);
		while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
	endtask

	always @(posedge core_clk) begin
		if ((psel & penable & pready & ~pwrite & rd_chk) === 1'b1)
			check("apb read", {pslverr, prdata}, exp_rd.size() ? exp_rd.pop_front() : 'x);
		if (rx_valid === 1'b1)
			check("ext rx byte", 33'(rx_data), 33'(exp_ext.size() ? exp_ext.pop_front() : 8'hxx));
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		miscompares++;
		final_report();
	end

	initial begin
		logic [31:0] q;
		logic [7:0]  b [5];
		for (int i = 0; i < 5; i++) begin
			lfsr = next_lfsr(lfsr);
			b[i] = lfsr[7:0];
		end
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, uart_pass_pkg::OFS_CTRL, '0, 1'b1, {1'b0, uart_pass_pkg::CTRL_RESET}, q);
		apb(1'b0, 12'h010, '0, 1'b1, 33'h1_0000_0000, q);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, uart_pass_pkg::OFS_CTRL, CFG[i][31:0], 1'b0, '0, q);
			apb(1'b0, uart_pass_pkg::OFS_STATUS, '0, 1'b0, '0, q);
			check("config bad", 33'(q[uart_pass_pkg::ST_CFG_BAD]), 33'(CFG[i][32]));
			check("enabled", 33'(q[uart_pass_pkg::ST_ENABLED]), 33'(CFG[i][33]));
			check("tx pin sel", 33'(gpio_tx_sel), 33'(CFG[i][33]));
			check("rts pin sel", 33'(gpio_rts_sel), 33'(CFG[i][34]));
		end
		// Both directions at once
		fork
			for (int i = 0; i < 2; i++) begin
				wait_st(uart_pass_pkg::ST_TX_FULL, 1'b0);
				exp_ext.push_back(b[i]);
				apb(1'b1, uart_pass_pkg::OFS_TXDATA, {24'h0, b[i]}, 1'b0, '0, q);
			end
			for (int j = 2; j < 4; j++) begin
				exp_dev.push_back(b[j]);
				ext_send(b[j]);
			end
		join
		wait_st(uart_pass_pkg::ST_RTS_HIGH, 1'b1);
		check("rts level", 33'(link.dev_rts_n), 33'h1);
		apb(1'b0, uart_pass_pkg::OFS_STATUS, '0, 1'b0, '0, q);
		check("rx valid", 33'(q[uart_pass_pkg::ST_RX_VALID]), 33'h1);
		repeat (4) @(posedge core_clk);
		check("ext ready", 33'(tx_ready), 33'h0);
		wait_st(uart_pass_pkg::ST_TX_FULL, 1'b0);
		wait_st(uart_pass_pkg::ST_TX_BUSY, 1'b0);
		rx_hold <= 1'b1;
		repeat (4) @(posedge core_clk);
		exp_ext.push_back(b[4]);
		apb(1'b1, uart_pass_pkg::OFS_TXDATA, {24'h0, b[4]}, 1'b0, '0, q);
		repeat (200) @(posedge core_clk);
		check("tx held", 33'(link.dev_tx), 33'h1);
		repeat (2) apb(1'b0, uart_pass_pkg::OFS_RXDATA, '0, 1'b1, {25'h1, exp_dev.pop_front()}, q);
		wait_st(uart_pass_pkg::ST_RTS_HIGH, 1'b0);
		check("rts low", 33'(link.dev_rts_n), 33'h0);
		apb(1'b0, uart_pass_pkg::OFS_RXDATA, '0, 1'b1, 33'h0, q);
		rx_hold <= 1'b0;
		for (int k = 0; k < 40000 && exp_ext.size() > 0; k++)
			@(posedge core_clk);
		check("ext drained", 33'(exp_ext.size()), 33'h0);
		final_report();
	end
endmodule

// ===== bench/uart_link_sva.sv
// Assertions on the serial link between the two UART ends
`timescale 1ns/100ps
module uart_link_sva #(
	parameter int DIV = 1736
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic dev_tx,
	input wire logic dev_rts_n,
	input wire logic ext_tx,
	input wire logic ext_cts_n
);
	int   dev_lo;
	int   ext_lo;
	int   dev_f;
	int   ext_f;
	int   cts_hi;
	int   rts_hi;
	logic dev_start;
	logic ext_start;

	// A start bit is a fall outside any frame
	assign dev_start = !dev_tx && dev_lo == 0 && dev_f == 0;
	assign ext_start = !ext_tx && ext_lo == 0 && ext_f == 0;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dev_lo <= 0;
			ext_lo <= 0;
			cts_hi <= 0;
			rts_hi <= 0;
		end else begin
			dev_lo <= dev_tx ? 0 : dev_lo + 1;
			ext_lo <= ext_tx ? 0 : ext_lo + 1;
			cts_hi <= ext_cts_n ? cts_hi + 1 : 0;
			rts_hi <= dev_rts_n ? rts_hi + 1 : 0;
		end
	end

	// Cycles left in the frame on each line
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dev_f <= 0;
			ext_f <= 0;
		end else begin
			dev_f <= dev_start ? 10 * DIV - 1 : (dev_f > 0 ? dev_f - 1 : 0);
			ext_f <= ext_start ? 10 * DIV - 1 : (ext_f > 0 ? ext_f - 1 : 0);
		end
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	a_reset_idle_lines: assert property ($rose(RST_N) |-> dev_tx && dev_rts_n && ext_tx && ext_cts_n)
		else $error("link lines not idle after reset");
	a_dev_low_run: assert property ($rose(dev_tx) |-> dev_lo % DIV == 0 && dev_lo <= 9 * DIV)
		else $error("device low run not whole bits");
	a_ext_low_run: assert property ($rose(ext_tx) |-> ext_lo % DIV == 0 && ext_lo <= 9 * DIV)
		else $error("external low run not whole bits");
	a_dev_start_bit: assert property (dev_f > 9 * DIV |-> !dev_tx)
		else $error("device start bit too short");
	a_dev_stop_bit: assert property (dev_f > 0 && dev_f <= DIV |-> dev_tx)
		else $error("device stop bit missing");
	a_ext_stop_bit: assert property (ext_f > 0 && ext_f <= DIV |-> ext_tx)
		else $error("external stop bit missing");
	a_cts_pauses_tx: assert property (dev_start |-> cts_hi < 6)
		else $error("device started while paused");
	a_rts_quiets_ext: assert property (ext_start |-> rts_hi < 6)
		else $error("external started while refused");
endmodule

// ===== verilog/uart_link_if.sv
// Serial link between the device UART and the external UART
`timescale 1ns/100ps
interface uart_link_if;
	logic dev_tx;
	logic dev_rts_n;
	logic ext_tx;
	logic ext_cts_n;

	modport dev (output dev_tx, output dev_rts_n, input ext_tx, input ext_cts_n);
	modport ext (input dev_tx, input dev_rts_n, output ext_tx, output ext_cts_n);
endinterface

// ===== verilog/uart_pass_dev.sv
// Device end: APB controlled pass-through UART
`timescale 1ns/100ps

// Behaviour
// - Frames are 8 data, 1 stop, no parity
// - Baud from five selectable rates
// - Enabled only with TX and RX assigned
// - RTS and CTS individually optional
// - Bytes forwarded unchanged both ways
// - Audio mode allows only 9600 baud
// - RTS required above 19200 without audio
// - Transmit paused while CTS high
// - RTS high when receive buffer nearly full
// - Partner stops sending while RTS high
// - Partner drives CTS low when ready
// - RX to host, host bytes to TX
// - Fixed pins each GPIO or serial
// - Flow pins need serial I/O enabled
// - Transmit and receive run independently
// - Host data over shared bulk endpoint
module uart_pass_dev #(
	parameter int unsigned DEPTH     = uart_pass_pkg::RX_DEPTH,
	parameter int unsigned NEAR_FULL = uart_pass_pkg::RX_NEAR_FULL
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic        CLK_EN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             GPIO_TX_SEL,
	output logic             GPIO_RTS_SEL,
	uart_link_if.dev         LINK
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [31:0]   ctrl;
	logic          enabled;
	logic          rts_used;
	logic          cts_used;
	logic          cfg_bad;
	logic [15:0]   div;
	logic          wr;
	logic          rd;
	logic [1:0]    rx_sync;
	logic [1:0]    cts_sync;
	logic          tx_busy;
	logic [3:0]    tx_bit;
	logic [15:0]   tx_cnt;
	logic [9:0]    tx_shift;
	logic          tx_pend;
	logic [7:0]    tx_hold;
	logic          rx_busy;
	logic [3:0]    rx_bit;
	logic [15:0]   rx_cnt;
	logic [7:0]    rx_shift;
	logic          rx_push;
	logic          rx_lost;
	logic [7:0]    rx_mem [DEPTH];
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] wr_ptr;
	logic [AW:0]   count;
	logic          pop;

	assign enabled  = ctrl[uart_pass_pkg::CTRL_TX_PIN] & ctrl[uart_pass_pkg::CTRL_RX_PIN];
	assign rts_used = enabled & ctrl[uart_pass_pkg::CTRL_SIO_EN] & ctrl[uart_pass_pkg::CTRL_RTS_PIN];
	assign cts_used = enabled & ctrl[uart_pass_pkg::CTRL_SIO_EN] & ctrl[uart_pass_pkg::CTRL_CTS_PIN];
	assign div      = uart_pass_pkg::baud_div(ctrl[uart_pass_pkg::CTRL_BAUD_LSB +: 3]);
	// Flag settings outside the supported table
	assign cfg_bad  = (ctrl[uart_pass_pkg::CTRL_AUDIO] && div != uart_pass_pkg::DIV_9600) ||
		(!ctrl[uart_pass_pkg::CTRL_AUDIO] && !rts_used && div < uart_pass_pkg::DIV_19200);

	assign GPIO_TX_SEL  = enabled;
	assign GPIO_RTS_SEL = rts_used;

	// APB slave, zero wait states
	assign PREADY  = 1'b1;
	assign wr      = PSEL & PENABLE & PWRITE;
	assign rd      = PSEL & PENABLE & ~PWRITE;
	assign PSLVERR = PSEL & PENABLE & (PADDR != uart_pass_pkg::OFS_CTRL) &
		(PADDR != uart_pass_pkg::OFS_STATUS) & (PADDR != uart_pass_pkg::OFS_TXDATA) &
		(PADDR != uart_pass_pkg::OFS_RXDATA);
	assign pop     = CLK_EN & rd & (PADDR == uart_pass_pkg::OFS_RXDATA) & (count != '0);

	always_comb begin
		PRDATA = 32'h0000_0000;
		if (PADDR == uart_pass_pkg::OFS_CTRL) begin
			PRDATA = ctrl;
		end else if (PADDR == uart_pass_pkg::OFS_STATUS) begin
			PRDATA[uart_pass_pkg::ST_ENABLED]  = enabled;
			PRDATA[uart_pass_pkg::ST_TX_BUSY]  = tx_busy;
			PRDATA[uart_pass_pkg::ST_RX_VALID] = (count != '0);
			PRDATA[uart_pass_pkg::ST_RX_LOST]  = rx_lost;
			PRDATA[uart_pass_pkg::ST_CFG_BAD]  = cfg_bad;
			PRDATA[uart_pass_pkg::ST_TX_FULL]  = tx_pend;
			PRDATA[uart_pass_pkg::ST_RTS_HIGH] = LINK.dev_rts_n;
			PRDATA[uart_pass_pkg::ST_CTS_HIGH] = cts_sync[1];
		end else if (PADDR == uart_pass_pkg::OFS_RXDATA) begin
			// An empty buffer reads as zero rather than a stale or unwritten entry
			if (count != '0) begin
				PRDATA[8:0] = {1'b1, rx_mem[rd_ptr]};
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl <= uart_pass_pkg::CTRL_RESET;
		end else if (CLK_EN && wr && PADDR == uart_pass_pkg::OFS_CTRL) begin
			ctrl <= PWDATA;
		end
	end

	// Pin synchronisers; RX idles high
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_sync  <= 2'h3;
			cts_sync <= 2'h3;
		end else if (CLK_EN) begin
			rx_sync  <= {rx_sync[0], LINK.ext_tx};
			cts_sync <= {cts_sync[0], LINK.ext_cts_n};
		end
	end

	// Host byte holding register, one deep
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_pend <= 1'b0;
			tx_hold <= 8'h00;
		end else if (CLK_EN) begin
			if (wr && PADDR == uart_pass_pkg::OFS_TXDATA && !tx_pend) begin
				tx_pend <= 1'b1;
				tx_hold <= PWDATA[7:0];
			end else if (tx_pend && !tx_busy && enabled && !(cts_used && cts_sync[1])) begin
				tx_pend <= 1'b0;
			end
		end
	end

	// Transmitter
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_busy  <= 1'b0;
			tx_bit   <= 4'h0;
			tx_cnt   <= 16'h0000;
			tx_shift <= 10'h3ff;
		end else if (CLK_EN) begin
			if (!tx_busy) begin
				tx_shift <= 10'h3ff;
				if (tx_pend && enabled && !(cts_used && cts_sync[1])) begin
					tx_busy  <= 1'b1;
					tx_bit   <= 4'h0;
					tx_cnt   <= div - 16'h0001;
					tx_shift <= {1'b1, tx_hold, 1'b0};
				end
			end else if (tx_cnt != 16'h0000) begin
				tx_cnt <= tx_cnt - 16'h0001;
			end else if (tx_bit == 4'(uart_pass_pkg::DATA_BITS + uart_pass_pkg::STOP_BITS)) begin
				tx_busy <= 1'b0;
			end else begin
				tx_bit   <= tx_bit + 4'h1;
				tx_cnt   <= div - 16'h0001;
				tx_shift <= {1'b1, tx_shift[9:1]};
			end
		end
	end
	assign LINK.dev_tx = tx_shift[0];

	// Receiver, samples mid bit
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_busy  <= 1'b0;
			rx_bit   <= 4'h0;
			rx_cnt   <= 16'h0000;
			rx_shift <= 8'h00;
			rx_push  <= 1'b0;
		end else if (CLK_EN) begin
			rx_push <= 1'b0;
			if (!rx_busy) begin
				if (enabled && !rx_sync[1]) begin
					rx_busy <= 1'b1;
					rx_bit  <= 4'h0;
					rx_cnt  <= {1'b0, div[15:1]};
				end
			end else if (rx_cnt != 16'h0000) begin
				rx_cnt <= rx_cnt - 16'h0001;
			end else begin
				rx_cnt <= div - 16'h0001;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0) begin
					rx_busy <= ~rx_sync[1];
				end else if (rx_bit <= 4'(uart_pass_pkg::DATA_BITS)) begin
					rx_shift <= {rx_sync[1], rx_shift[7:1]};
				end else begin
					rx_busy <= 1'b0;
					rx_push <= rx_sync[1];
				end
			end
		end
	end

	// Receive buffer toward the host
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			count   <= '0;
			rx_lost <= 1'b0;
		end else if (CLK_EN) begin
			if (rx_push && count != (AW+1)'(DEPTH)) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(rx_push && count != (AW+1)'(DEPTH)) - (AW+1)'(pop);
			if (rx_push && count == (AW+1)'(DEPTH)) begin
				rx_lost <= 1'b1;
			end else if (wr && PADDR == uart_pass_pkg::OFS_STATUS && PWDATA[uart_pass_pkg::ST_RX_LOST]) begin
				rx_lost <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (CLK_EN && rx_push && count != (AW+1)'(DEPTH)) begin
			rx_mem[wr_ptr] <= rx_shift;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LINK.dev_rts_n <= 1'b1;
		end else if (CLK_EN) begin
			LINK.dev_rts_n <= rts_used ? (count >= (AW+1)'(NEAR_FULL)) : ~enabled;
		end
	end
endmodule

// ===== verilog/uart_pass_ext.sv
// External end: partner UART with byte handshake ports
`timescale 1ns/100ps
module uart_pass_ext #(
	parameter logic [15:0] DIV = uart_pass_pkg::DIV_9600
) (
	input  wire logic       CORE_CLK,
	input  wire logic       RST_N,
	input  wire logic       CLK_EN,
	input  wire logic       TX_VALID,
	input  wire logic [7:0] TX_DATA,
	output logic            TX_READY,
	output logic            RX_VALID,
	output logic      [7:0] RX_DATA,
	input  wire logic       RX_HOLD,
	uart_link_if.ext        LINK
);
	logic [1:0]  rx_sync;
	logic [1:0]  rts_sync;
	logic        tx_busy;
	logic [3:0]  tx_bit;
	logic [15:0] tx_cnt;
	logic [9:0]  tx_shift;
	logic        rx_busy;
	logic [3:0]  rx_bit;
	logic [15:0] rx_cnt;
	logic [7:0]  rx_shift;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_sync  <= 2'h3;
			rts_sync <= 2'h3;
		end else if (CLK_EN) begin
			rx_sync  <= {rx_sync[0], LINK.dev_tx};
			rts_sync <= {rts_sync[0], LINK.dev_rts_n};
		end
	end

	assign TX_READY = ~tx_busy & ~rts_sync[1];

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_busy  <= 1'b0;
			tx_bit   <= 4'h0;
			tx_cnt   <= 16'h0000;
			tx_shift <= 10'h3ff;
		end else if (CLK_EN) begin
			if (!tx_busy) begin
				if (TX_VALID && TX_READY) begin
					tx_busy  <= 1'b1;
					tx_bit   <= 4'h0;
					tx_cnt   <= DIV - 16'h0001;
					tx_shift <= {1'b1, TX_DATA, 1'b0};
				end
			end else if (tx_cnt != 16'h0000) begin
				tx_cnt <= tx_cnt - 16'h0001;
			end else if (tx_bit == 4'(uart_pass_pkg::DATA_BITS + uart_pass_pkg::STOP_BITS)) begin
				tx_busy <= 1'b0;
			end else begin
				tx_bit   <= tx_bit + 4'h1;
				tx_cnt   <= DIV - 16'h0001;
				tx_shift <= {1'b1, tx_shift[9:1]};
			end
		end
	end
	assign LINK.ext_tx = tx_shift[0];

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_busy  <= 1'b0;
			rx_bit   <= 4'h0;
			rx_cnt   <= 16'h0000;
			rx_shift <= 8'h00;
			RX_VALID <= 1'b0;
			RX_DATA  <= 8'h00;
		end else if (CLK_EN) begin
			RX_VALID <= 1'b0;
			if (!rx_busy) begin
				if (!rx_sync[1]) begin
					rx_busy <= 1'b1;
					rx_bit  <= 4'h0;
					rx_cnt  <= {1'b0, DIV[15:1]};
				end
			end else if (rx_cnt != 16'h0000) begin
				rx_cnt <= rx_cnt - 16'h0001;
			end else begin
				rx_cnt <= DIV - 16'h0001;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0) begin
					rx_busy <= ~rx_sync[1];
				end else if (rx_bit <= 4'(uart_pass_pkg::DATA_BITS)) begin
					rx_shift <= {rx_sync[1], rx_shift[7:1]};
				end else begin
					rx_busy  <= 1'b0;
					RX_VALID <= rx_sync[1];
					RX_DATA  <= rx_shift;
				end
			end
		end
	end

	// Low means ready to take data from the device
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LINK.ext_cts_n <= 1'b1;
		end else if (CLK_EN) begin
			LINK.ext_cts_n <= RX_HOLD;
		end
	end
endmodule

// ===== verilog/uart_pass_pkg.sv
// Shared constants for the pass-through UART and its external partner
package uart_pass_pkg;
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned DATA_BITS     = 8;
	localparam int unsigned STOP_BITS     = 1;
	localparam int unsigned BAUD_115200   = 115200;
	localparam int unsigned BAUD_57600    = 57600;
	localparam int unsigned BAUD_38400    = 38400;
	localparam int unsigned BAUD_19200    = 19200;
	localparam int unsigned BAUD_9600     = 9600;
	localparam int unsigned RTS_FREE_MAX  = BAUD_19200;
	localparam int unsigned AUDIO_BAUD    = BAUD_9600;
	// Baud selection codes
	localparam logic [2:0]  SEL_115200    = 3'h0;
	localparam logic [2:0]  SEL_57600     = 3'h1;
	localparam logic [2:0]  SEL_38400     = 3'h2;
	localparam logic [2:0]  SEL_19200     = 3'h3;
	localparam logic [2:0]  SEL_9600      = 3'h4;
	// Bit periods in CORE_CLK cycles
	localparam logic [15:0] DIV_115200    = 16'(CLK_HZ / BAUD_115200);
	localparam logic [15:0] DIV_57600     = 16'(CLK_HZ / BAUD_57600);
	localparam logic [15:0] DIV_38400     = 16'(CLK_HZ / BAUD_38400);
	localparam logic [15:0] DIV_19200     = 16'(CLK_HZ / BAUD_19200);
	localparam logic [15:0] DIV_9600      = 16'(CLK_HZ / BAUD_9600);
	// APB register offsets of the device end
	localparam logic [11:0] OFS_CTRL      = 12'h000;
	localparam logic [11:0] OFS_STATUS    = 12'h004;
	localparam logic [11:0] OFS_TXDATA    = 12'h008;
	localparam logic [11:0] OFS_RXDATA    = 12'h00c;
	// CTRL fields
	localparam int unsigned CTRL_TX_PIN   = 0;
	localparam int unsigned CTRL_RX_PIN   = 1;
	localparam int unsigned CTRL_RTS_PIN  = 2;
	localparam int unsigned CTRL_CTS_PIN  = 3;
	localparam int unsigned CTRL_AUDIO    = 4;
	localparam int unsigned CTRL_SIO_EN   = 5;
	localparam int unsigned CTRL_BAUD_LSB = 8;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	// STATUS fields
	localparam int unsigned ST_ENABLED    = 0;
	localparam int unsigned ST_TX_BUSY    = 1;
	localparam int unsigned ST_RX_VALID   = 2;
	localparam int unsigned ST_RX_LOST    = 3;
	localparam int unsigned ST_CFG_BAD    = 4;
	localparam int unsigned ST_TX_FULL    = 5;
	localparam int unsigned ST_RTS_HIGH   = 6;
	localparam int unsigned ST_CTS_HIGH   = 7;
	localparam int unsigned RX_DEPTH      = 8;
	localparam int unsigned RX_NEAR_FULL  = 6;

	function automatic logic [15:0] baud_div(input logic [2:0] sel);
		case (sel)
			SEL_115200: baud_div = DIV_115200;
			SEL_57600:  baud_div = DIV_57600;
			SEL_38400:  baud_div = DIV_38400;
			SEL_19200:  baud_div = DIV_19200;
			default:    baud_div = DIV_9600;
		endcase
	endfunction
endpackage
